// >>> rcd_pkg.sv
// types of the reset cause and delay block
package rcd_pkg;
   typedef enum logic [3:0] {
      RCD_EC, RCD_FRC, RCD_FRCDIV, RCD_LPRC, RCD_ECPLL, RCD_FRCPLL,
      RCD_XT, RCD_HS, RCD_SOSC, RCD_XTPLL, RCD_HSPLL
   } rcd_clk_src_e;
   typedef enum logic [2:0] {
      RCD_ST_POR, RCD_ST_PWRT, RCD_ST_RST, RCD_ST_FRC,
      RCD_ST_LPRC, RCD_ST_OST, RCD_ST_LOCK, RCD_ST_RUN
   } rcd_state_e;
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } rcd_axil_req_s;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } rcd_axil_rsp_s;
endpackage

// >>> rcd_regs.svh
// register map, field positions, reset values and timing counts
`ifndef RCD_REGS_SVH
`define RCD_REGS_SVH
// ==========================
// register offsets
`define RCD_OFF_CAUSE      8'h00
`define RCD_OFF_EVT        8'h04
`define RCD_OFF_MASK       8'h08
`define RCD_OFF_SEQ        8'h0C
// ==========================
// reset_cause_status fields
`define RCD_B_TRAP         15
`define RCD_B_ILLOP        14
`define RCD_B_CFGMIS       9
`define RCD_B_PMSLP        8
`define RCD_B_EXTR         7
`define RCD_B_SWR          6
`define RCD_B_WDSOFT       5
`define RCD_B_WDTO         4
`define RCD_B_SLEEP        3
`define RCD_B_IDLE         2
`define RCD_B_BOR          1
`define RCD_B_POR          0
`define RCD_CAUSE_WMASK    16'hC3FF
`define RCD_CAUSE_RST      16'h0003
// ==========================
// event bits
`define RCD_EV_START       0
`define RCD_EV_SYSREL      1
`define RCD_EV_CLKREL      2
`define RCD_EV_RST         3'h0
`define RCD_MASK_RST       3'h0
// ==========================
// timing
`define RCD_CLK_NS         10
`define RCD_POR_NS         10000
`define RCD_PWRT_NS        64000000
`define RCD_RST_NS         10000
`define RCD_FRC_NS         15000
`define RCD_LPRC_NS        50000
`define RCD_LOCK_NS        200000
`define RCD_POR_CYC        (`RCD_POR_NS / `RCD_CLK_NS)
`define RCD_PWRT_CYC       (`RCD_PWRT_NS / `RCD_CLK_NS)
`define RCD_RST_CYC        (`RCD_RST_NS / `RCD_CLK_NS)
`define RCD_FRC_CYC        (`RCD_FRC_NS / `RCD_CLK_NS)
`define RCD_LPRC_CYC       (`RCD_LPRC_NS / `RCD_CLK_NS)
`define RCD_LOCK_CYC       (`RCD_LOCK_NS / `RCD_CLK_NS)
`define RCD_OST_LAST       10'h3FF
`define RCD_RESP_OK        2'h0
`define RCD_RESP_ERR       2'h2
`endif

// >>> rcd_reset_cause.sv
// reset cause recording and reset release sequencer with axi4-lite registers
// Function
// - power-on holds reset for power-on delay, power-up timer, then state reset timer
// - power-up timer is 64 ms when the regulator enable pin is low
// - crystal and secondary sources wait 1024 oscillator periods on a 10-bit counter, but crystal pll sources after brown-out wait the fast rc time
// - two-speed start-up runs fast rc first and applies its start-up delay
// - pll sources add the pll lock time before the clock is delivered, except with two-speed start-up, which skips it
// - fast rc source, or low-power rc source without two-speed start-up, adds its start-up time
// - other reset types wait only the state reset timer, no clock delay
// - idle-wake flag is set after idle mode or by a software write and stays clear otherwise
// - watchdog soft enable bit turns the watchdog on and off; wdt_forced_on keeps it on
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_regs.svh"
module rcd_reset_cause #(
   parameter int unsigned POR_CYC  = `RCD_POR_CYC,
   parameter int unsigned PWRT_CYC = `RCD_PWRT_CYC,
   parameter int unsigned RST_CYC  = `RCD_RST_CYC,
   parameter int unsigned FRC_CYC  = `RCD_FRC_CYC,
   parameter int unsigned LPRC_CYC = `RCD_LPRC_CYC,
   parameter int unsigned LOCK_CYC = `RCD_LOCK_CYC
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire rcd_pkg::rcd_axil_req_s s_axi_req,
   output var  rcd_pkg::rcd_axil_rsp_s s_axi_rsp,
   input  wire logic                  power_on_event,
   input  wire logic                  brownout_reset_event,
   input  wire logic                  ext_reset_event,
   input  wire logic                  soft_reset_event,
   input  wire logic                  wdt_timeout_event,
   input  wire logic                  trap_reset_event,
   input  wire logic                  illegal_op_event,
   input  wire logic                  cfg_mismatch_event,
   input  wire logic                  sleep_entry,
   input  wire logic                  idle_entry,
   input  wire logic                  regulator_enable_pin,
   input  wire logic                  two_speed_en,
   input  wire rcd_pkg::rcd_clk_src_e  clk_source,
   input  wire logic                  osc_tick,
   input  wire logic                  wdt_forced_on,
   output var  logic                  system_reset_signal,
   output var  logic                  sys_clk_enable,
   output var  logic                  watchdog_enable,
   output var  logic                  irq
);
   import rcd_pkg::*;

   // ==========================
   // sequencer state
   rcd_state_e    state_q, state_d;
   logic [31:0]   cnt_q;
   logic [9:0]    ost_q;
   logic          full_q;
   logic          bor_q;
   rcd_clk_src_e  src_q;
   logic          two_q;
   logic [15:0]   cause_q, cause_d;
   logic [2:0]    evt_q, evt_d;
   logic [2:0]    mask_q;
   rcd_axil_rsp_s rsp_q;
   logic          aw_full_q, w_full_q;
   logic [7:0]    aw_addr_q, ar_addr_q;
   logic [31:0]   w_data_q;
   logic [3:0]    w_strb_q;
   logic          ar_full_q;
   logic          system_reset_signal_q, clken_q, wden_q, irq_q;

   // ==========================
   // reset kind decode
   wire any_other = ext_reset_event | soft_reset_event | wdt_timeout_event
                  | trap_reset_event | illegal_op_event | cfg_mismatch_event;
   wire start_por = power_on_event;
   wire start_bor = ~power_on_event & brownout_reset_event;
   wire start_oth = ~power_on_event & ~brownout_reset_event & any_other;
   wire start_any = start_por | start_bor | start_oth;
   wire [2:0] pwrt_first = regulator_enable_pin ? RCD_ST_RST : RCD_ST_PWRT;

   // ==========================
   // clock delay selection
   wire src_frc  = src_q == RCD_FRC || src_q == RCD_FRCDIV || src_q == RCD_FRCPLL;
   wire src_xpll = src_q == RCD_XTPLL || src_q == RCD_HSPLL;
   wire src_pll  = src_xpll || src_q == RCD_ECPLL || src_q == RCD_FRCPLL;
   wire src_osc  = src_q == RCD_XT || src_q == RCD_HS || src_q == RCD_SOSC;
   wire need_frc  = two_q | src_frc | (bor_q & src_xpll);
   wire need_lprc = ~two_q & (src_q == RCD_LPRC);
   wire need_ost  = ~two_q & (src_osc | (~bor_q & src_xpll));
   wire need_lock = ~two_q & src_pll;
   wire [2:0] after_rst  = ~full_q   ? RCD_ST_RUN :
                           need_frc  ? RCD_ST_FRC :
                           need_lprc ? RCD_ST_LPRC :
                           need_ost  ? RCD_ST_OST :
                           need_lock ? RCD_ST_LOCK : RCD_ST_RUN;
   wire [2:0] after_clk  = need_lock ? RCD_ST_LOCK : RCD_ST_RUN;
   wire ost_done = osc_tick && ost_q == `RCD_OST_LAST;
   wire cnt_done = cnt_q == 32'h0;

   // ==========================
   // phase timer load values
   function automatic logic [31:0] load_for(rcd_state_e s);
      case (s)
         RCD_ST_POR:  load_for = 32'(POR_CYC - 1);
         RCD_ST_PWRT: load_for = 32'(PWRT_CYC - 1);
         RCD_ST_RST:  load_for = 32'(RST_CYC - 1);
         RCD_ST_FRC:  load_for = 32'(FRC_CYC - 1);
         RCD_ST_LPRC: load_for = 32'(LPRC_CYC - 1);
         RCD_ST_LOCK: load_for = 32'(LOCK_CYC - 1);
         default:     load_for = 32'h0;
      endcase
   endfunction

   // ==========================
   // next phase
   always_comb begin
      state_d = state_q;
      if (start_por) begin
         state_d = RCD_ST_POR;
      end else if (start_bor) begin
         state_d = rcd_state_e'(pwrt_first);
      end else if (start_oth) begin
         state_d = RCD_ST_RST;
      end else begin
         case (state_q)
            RCD_ST_POR:  if (cnt_done) state_d = rcd_state_e'(pwrt_first);
            RCD_ST_PWRT: if (cnt_done) state_d = RCD_ST_RST;
            RCD_ST_RST:  if (cnt_done) state_d = rcd_state_e'(after_rst);
            RCD_ST_FRC:  if (cnt_done) state_d = rcd_state_e'(after_clk);
            RCD_ST_LPRC: if (cnt_done) state_d = rcd_state_e'(after_clk);
            RCD_ST_OST:  if (ost_done) state_d = rcd_state_e'(after_clk);
            RCD_ST_LOCK: if (cnt_done) state_d = RCD_ST_RUN;
            RCD_ST_RUN:  state_d = RCD_ST_RUN;
            default:     state_d = RCD_ST_RUN;
         endcase
      end
   end

   // ==========================
   // phase registers
   wire moving  = start_any || state_d != state_q;
   wire hold_d  = state_d == RCD_ST_POR || state_d == RCD_ST_PWRT || state_d == RCD_ST_RST;
   wire run_d   = state_d == RCD_ST_RUN;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= RCD_ST_POR;
         cnt_q   <= 32'(POR_CYC - 1);
         ost_q   <= 10'h000;
         full_q  <= 1'b1;
         bor_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= moving ? load_for(state_d) : (cnt_done ? cnt_q : cnt_q - 32'h1);
         ost_q   <= moving ? 10'h000 : (osc_tick ? ost_q + 10'h001 : ost_q);
         if (start_any) begin
            full_q <= start_por | start_bor;
            bor_q  <= start_bor;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_q <= RCD_EC;
         two_q <= 1'b0;
      end else if (hold_d) begin
         src_q <= clk_source;
         two_q <= two_speed_en;
      end
   end

   // ==========================
   // axi4-lite write path
   wire aw_take  = s_axi_req.awvalid & rsp_q.awready;
   wire w_take   = s_axi_req.wvalid & rsp_q.wready;
   wire wr_fire  = aw_full_q & w_full_q & ~rsp_q.bvalid;
   wire b_done   = rsp_q.bvalid & s_axi_req.bready;
   wire aw_hit   = aw_addr_q == `RCD_OFF_CAUSE || aw_addr_q == `RCD_OFF_EVT
                || aw_addr_q == `RCD_OFF_MASK  || aw_addr_q == `RCD_OFF_SEQ;
   wire [15:0] be16 = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire cause_wr = wr_fire && aw_addr_q == `RCD_OFF_CAUSE;
   wire mask_wr  = wr_fire && aw_addr_q == `RCD_OFF_MASK && w_strb_q[0];
   wire [15:0] cw_mask = be16 & `RCD_CAUSE_WMASK;
   wire aw_full_d = (aw_full_q & ~wr_fire) | aw_take;
   wire w_full_d  = (w_full_q & ~wr_fire) | w_take;
   wire bvalid_d  = (rsp_q.bvalid & ~b_done) | wr_fire;

   // ==========================
   // axi4-lite read path
   wire ar_take  = s_axi_req.arvalid & rsp_q.arready;
   wire rd_fire  = ar_full_q & ~rsp_q.rvalid;
   wire r_done   = rsp_q.rvalid & s_axi_req.rready;
   wire ar_full_d = (ar_full_q & ~rd_fire) | ar_take;
   wire rvalid_d  = (rsp_q.rvalid & ~r_done) | rd_fire;
   wire rd_cause = ar_addr_q == `RCD_OFF_CAUSE;
   wire rd_evt   = ar_addr_q == `RCD_OFF_EVT;
   wire rd_mask  = ar_addr_q == `RCD_OFF_MASK;
   wire rd_seq   = ar_addr_q == `RCD_OFF_SEQ;
   wire rd_hit   = rd_cause | rd_evt | rd_mask | rd_seq;
   wire [31:0] rd_mux = rd_cause ? {16'h0000, cause_q} :
                        rd_evt   ? {29'h0, evt_q} :
                        rd_mask  ? {29'h0, mask_q} :
                        rd_seq   ? {26'h0, clken_q, system_reset_signal_q, 1'b0, state_q} : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         ar_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         ar_addr_q <= 8'h00;
         w_data_q  <= 32'h0;
         w_strb_q  <= 4'h0;
         rsp_q     <= '0;
      end else begin
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         ar_full_q     <= ar_full_d;
         if (aw_take) aw_addr_q <= {s_axi_req.awaddr[7:2], 2'b00};
         if (w_take) begin
            w_data_q <= s_axi_req.wdata;
            w_strb_q <= s_axi_req.wstrb;
         end
         if (ar_take) ar_addr_q <= {s_axi_req.araddr[7:2], 2'b00};
         rsp_q.awready <= ~aw_full_d & ~bvalid_d;
         rsp_q.wready  <= ~w_full_d & ~bvalid_d;
         rsp_q.bvalid  <= bvalid_d;
         if (wr_fire) rsp_q.bresp <= aw_hit ? `RCD_RESP_OK : `RCD_RESP_ERR;
         rsp_q.arready <= ~ar_full_d & ~rvalid_d;
         rsp_q.rvalid  <= rvalid_d;
         if (rd_fire) begin
            rsp_q.rdata <= rd_mux;
            rsp_q.rresp <= rd_hit ? `RCD_RESP_OK : `RCD_RESP_ERR;
         end
      end
   end

   // ==========================
   // cause flags: hardware set wins over software clear
   logic [15:0] hw_set;
   always_comb begin
      hw_set                = 16'h0000;
      hw_set[`RCD_B_POR]    = start_por;
      hw_set[`RCD_B_BOR]    = start_por | brownout_reset_event;
      hw_set[`RCD_B_EXTR]   = ext_reset_event;
      hw_set[`RCD_B_SWR]    = soft_reset_event;
      hw_set[`RCD_B_WDTO]   = wdt_timeout_event;
      hw_set[`RCD_B_TRAP]   = trap_reset_event;
      hw_set[`RCD_B_ILLOP]  = illegal_op_event;
      hw_set[`RCD_B_CFGMIS] = cfg_mismatch_event;
      hw_set[`RCD_B_SLEEP]  = sleep_entry;
      hw_set[`RCD_B_IDLE]   = idle_entry;
      cause_d = cause_q;
      if (cause_wr) begin
         cause_d = (cause_q & ~cw_mask) | (w_data_q[15:0] & cw_mask);
      end
      cause_d = cause_d | hw_set;
   end

   // ==========================
   // event status, mask and interrupt
   wire [2:0] ev_set = {clken_q == 1'b0 && run_d,
                        system_reset_signal_q && !hold_d,
                        start_any};
   always_comb begin
      evt_d = evt_q;
      if (rd_fire && rd_evt) begin
         evt_d = 3'h0;
      end
      evt_d = evt_d | ev_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_q  <= `RCD_CAUSE_RST;
         evt_q    <= `RCD_EV_RST;
         mask_q   <= `RCD_MASK_RST;
         system_reset_signal_q <= 1'b1;
         clken_q  <= 1'b0;
         wden_q   <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         cause_q  <= cause_d;
         evt_q    <= evt_d;
         if (mask_wr) mask_q <= w_data_q[2:0];
         system_reset_signal_q <= hold_d;
         clken_q  <= run_d;
         wden_q   <= cause_d[`RCD_B_WDSOFT] | wdt_forced_on;
         irq_q    <= |(evt_d & mask_q);
      end
   end

   // ==========================
   // outputs straight from flops
   assign s_axi_rsp           = rsp_q;
   assign system_reset_signal = system_reset_signal_q;
   assign sys_clk_enable      = clken_q;
   assign watchdog_enable     = wden_q;
   assign irq                 = irq_q;

endmodule
`default_nettype wire

// >>> rcd_reset_cause_checker.sv
// concurrent checks on the ports of the reset cause and delay block
`timescale 1ns/1ps
`default_nettype none
module rcd_reset_cause_checker (
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire rcd_pkg::rcd_axil_req_s s_axi_req,
   input wire rcd_pkg::rcd_axil_rsp_s s_axi_rsp,
   input wire logic                   power_on_event,
   input wire logic                   brownout_reset_event,
   input wire logic                   ext_reset_event,
   input wire logic                   wdt_forced_on,
   input wire logic                   system_reset_signal,
   input wire logic                   sys_clk_enable,
   input wire logic                   watchdog_enable,
   input wire logic                   irq
);
   import rcd_pkg::*;
   wire any_ev  = power_on_event | brownout_reset_event | ext_reset_event;
   wire wr_fire = s_axi_req.awvalid & s_axi_rsp.awready & s_axi_req.wvalid & s_axi_rsp.wready;
   wire rd_fire = s_axi_req.arvalid & s_axi_rsp.arready;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================
   // sequencer
   chk_clk_after_rel: assert property (sys_clk_enable |-> !system_reset_signal)
      else $error("clock delivered while reset held");
   chk_evt_restart: assert property (any_ev |=> system_reset_signal && !sys_clk_enable)
      else $error("reset event did not restart hold");
   chk_wdt_forced: assert property (wdt_forced_on |=> watchdog_enable)
      else $error("forced watchdog not enabled");
   // ==========================
   // register bus
   chk_b_stable: assert property (s_axi_rsp.bvalid && !s_axi_req.bready |=> s_axi_rsp.bvalid && $stable(s_axi_rsp.bresp))
      else $error("write response dropped early");
   chk_r_stable: assert property (s_axi_rsp.rvalid && !s_axi_req.rready |=> s_axi_rsp.rvalid && $stable(s_axi_rsp.rdata))
      else $error("read data dropped early");
   chk_b_latency: assert property (wr_fire |-> ##2 s_axi_rsp.bvalid)
      else $error("write response late");
   chk_r_latency: assert property (rd_fire |-> ##1 !s_axi_rsp.arready ##1 s_axi_rsp.rvalid)
      else $error("read answer late");
   chk_wr_busy: assert property (s_axi_rsp.bvalid |-> !s_axi_rsp.awready && !s_axi_rsp.wready)
      else $error("write taken while response pending");
   cov_irq: cover property ($rose(irq));
   cov_clk_rel: cover property ($rose(sys_clk_enable));
   cov_write: cover property (wr_fire);
endmodule
`default_nettype wire

// >>> tb_rcd_reset_cause.sv
// self-checking testbench of the reset cause and delay block
`timescale 1ns/1ps
`default_nettype none
`include "rcd_regs.svh"
module tb_rcd_reset_cause;
   import rcd_pkg::*;
   localparam int PORC = 4, PWRC = 6, RSTC = 3, FRCC = 5, LPRC = 7, LCKC = 8, OST = 2048;
   logic          aclk, aresetn, reg_pin, two_spd, wdt_on, idle_in, sleep_in;
   logic          osc_tick = 1'b0;
   logic [7:0]    ev_q;
   rcd_clk_src_e  src;
   rcd_axil_req_s req;
   rcd_axil_rsp_s rsp;
   logic          sys_rst, clk_en, wdt_en, irq;
   logic [31:0]   rd;
   logic [1:0]    rr;
   int            fails, n_tests, h0, h, d;
   int            cyc = 0;
   int            t_ev [10] = '{0, 0, 0, 0, 0, 1, 0, 0, 1, 0};
   rcd_clk_src_e  t_src [10] = '{RCD_FRC, RCD_FRCDIV, RCD_LPRC, RCD_ECPLL, RCD_FRCPLL,
                                 RCD_HSPLL, RCD_HS, RCD_XT, RCD_SOSC, RCD_HSPLL};
   logic          t_ts [10] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0};
   int            t_ex [10] = '{FRCC, FRCC, LPRC, LCKC, FRCC + LCKC, FRCC + LCKC, FRCC, OST, OST, OST + LCKC};
   rcd_reset_cause #(.POR_CYC(PORC), .PWRT_CYC(PWRC), .RST_CYC(RSTC), .FRC_CYC(FRCC), .LPRC_CYC(LPRC),
      .LOCK_CYC(LCKC)) rcd_reset_cause_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
      .power_on_event(ev_q[0]), .brownout_reset_event(ev_q[1]), .ext_reset_event(ev_q[2]),
      .soft_reset_event(ev_q[3]), .wdt_timeout_event(ev_q[4]), .trap_reset_event(ev_q[5]),
      .illegal_op_event(ev_q[6]), .cfg_mismatch_event(ev_q[7]), .sleep_entry(sleep_in), .idle_entry(idle_in),
      .regulator_enable_pin(reg_pin), .two_speed_en(two_spd), .clk_source(src), .osc_tick(osc_tick),
      .wdt_forced_on(wdt_on), .system_reset_signal(sys_rst), .sys_clk_enable(clk_en),
      .watchdog_enable(wdt_en), .irq(irq));
   // ==========================
   // clock, timeout and helpers
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      osc_tick <= ~osc_tick;
      if (cyc > 20000) begin
         fails++;
         wrap_up();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task axi_wr(input logic [7:0] a, input logic [31:0] dat, input int lag = 0);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= dat;
      req.wstrb <= 4'hF;
      req.bready <= (lag == 0);
      while (!(aw && w)) begin
         @(posedge aclk);
         if (rsp.awready === 1'b1) aw = 1'b1;
         if (rsp.wready === 1'b1) w = 1'b1;
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end
      repeat (lag) @(posedge aclk);
      req.bready <= 1'b1;
      do @(posedge aclk); while (rsp.bvalid !== 1'b1);
      rr = rsp.bresp;
      req.bready <= 1'b0;
   endtask
   task axi_rd(input logic [7:0] a, input int lag = 0);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= (lag == 0);
      do @(posedge aclk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      repeat (lag) @(posedge aclk);
      req.rready <= 1'b1;
      do @(posedge aclk); while (rsp.rvalid !== 1'b1);
      rd = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   task run_seq(input int ev, input rcd_clk_src_e s, input logic ts, input logic pin);
      @(posedge aclk);
      src <= s;
      two_spd <= ts;
      reg_pin <= pin;
      ev_q <= 8'h01 << ev;
      @(posedge aclk);
      ev_q <= 8'h00;
      h = 0;
      d = 0;
      #1;
      while (sys_rst !== 1'b0) begin
         @(posedge aclk);
         #1;
         h++;
      end
      while (clk_en !== 1'b1) begin
         @(posedge aclk);
         #1;
         d++;
      end
   endtask
   // ==========================
   // scenarios
   task t_regs();
      while (clk_en !== 1'b1) @(posedge aclk);
      axi_rd(`RCD_OFF_CAUSE);
      chk(rd, 32'h0000_0003);
      axi_rd(`RCD_OFF_MASK);
      chk(rd, 32'h0000_0000);
      axi_rd(`RCD_OFF_SEQ, 3);
      chk(rd, 32'h0000_0027);
      axi_rd(8'h10);
      chk(rd, 32'h0);
      chk(rr, `RCD_RESP_ERR);
      axi_wr(8'h10, 32'h0000_FFFF, 3);
      chk(rr, `RCD_RESP_ERR);
      $display("test regs done");
   endtask
   task t_hold();
      run_seq(2, RCD_EC, 1'b0, 1'b0);
      h0 = h;
      chk(h0, RSTC);
      for (int e = 3; e < 8; e++) begin
         run_seq(e, RCD_XTPLL, 1'b0, 1'b0);
         chk(h, h0);
         chk(d, 32'd0);
      end
      run_seq(0, RCD_EC, 1'b0, 1'b0);
      chk(h - h0, PORC + PWRC);
      run_seq(0, RCD_EC, 1'b0, 1'b1);
      chk(h - h0, PORC);
      run_seq(1, RCD_EC, 1'b0, 1'b0);
      chk(h - h0, PWRC);
      $display("test hold done");
   endtask
   task t_clk();
      for (int i = 0; i < 10; i++) begin
         run_seq(t_ev[i], t_src[i], t_ts[i], 1'b1);
         chk(d >= t_ex[i] - (t_ex[i] >= OST) && d <= t_ex[i], 1'b1);
      end
      $display("test clock delay done");
   endtask
   task t_cause();
      axi_wr(`RCD_OFF_CAUSE, 32'h0);
      for (int e = 2; e < 8; e++) run_seq(e, RCD_EC, 1'b0, 1'b0);
      axi_rd(`RCD_OFF_CAUSE);
      chk(rd, 32'h0000_C2D0);
      @(posedge aclk);
      idle_in <= 1'b1;
      sleep_in <= 1'b1;
      @(posedge aclk);
      idle_in <= 1'b0;
      sleep_in <= 1'b0;
      axi_rd(`RCD_OFF_CAUSE);
      chk(rd, 32'h0000_C2DC);
      axi_wr(`RCD_OFF_CAUSE, 32'h0000_FFFF);
      chk({sys_rst, wdt_en}, 2'b01);
      axi_rd(`RCD_OFF_CAUSE);
      chk(rd, 32'h0000_C3FF);
      axi_wr(`RCD_OFF_CAUSE, 32'h0);
      chk(wdt_en, 1'b0);
      wdt_on <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(wdt_en, 1'b1);
      wdt_on <= 1'b0;
      $display("test cause done");
   endtask
   task t_irq();
      axi_wr(`RCD_OFF_MASK, 32'h0);
      axi_rd(`RCD_OFF_EVT);
      run_seq(2, RCD_EC, 1'b0, 1'b0);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      axi_wr(`RCD_OFF_EVT, 32'h0);
      chk(rr, `RCD_RESP_OK);
      axi_rd(`RCD_OFF_EVT);
      chk(rd, 32'h7);
      axi_wr(`RCD_OFF_MASK, 32'h4);
      run_seq(2, RCD_EC, 1'b0, 1'b0);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1);
      axi_rd(`RCD_OFF_EVT);
      chk(rd, 32'h7);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
      $display("test irq done");
   endtask
   initial begin
      fails = 0;
      n_tests = 0;
      aresetn = 1'b0;
      req = '0;
      ev_q = 8'h00;
      src = RCD_EC;
      {reg_pin, two_spd, wdt_on, idle_in, sleep_in} = 5'h00;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_hold();
      t_clk();
      t_cause();
      t_irq();
      wrap_up();
   end
endmodule
bind rcd_reset_cause rcd_reset_cause_checker rcd_reset_cause_checker_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp), .power_on_event(power_on_event),
   .brownout_reset_event(brownout_reset_event), .ext_reset_event(ext_reset_event),
   .wdt_forced_on(wdt_forced_on), .system_reset_signal(system_reset_signal),
   .sys_clk_enable(sys_clk_enable), .watchdog_enable(watchdog_enable), .irq(irq));
`default_nettype wire
